// file: core/gsd_top.sv
// GPIO, strap, debug, scan enable, EEPROM pin and test port pin logic
`timescale 1ns/1ps
module gsd_top
    import gsd_pkg::*;
(
    // Clock and reset
    input wire logic SYS_CLK_I,
    input wire logic RSTN_I,
    // General-purpose pins
    input wire logic [7:0] GPIO_I,
    output logic [7:0] GPIO_O,
    output logic [7:0] GPIO_OE_O,
    // GPIO control and status
    input wire logic GPIO_OE_WR_I,
    input wire logic [7:0] GPIO_OE_WDATA_I,
    input wire logic GPIO_OUT_WR_I,
    input wire logic [7:0] GPIO_OUT_WDATA_I,
    output logic [7:0] GPIO_IN_O,
    // Management bus address straps
    input wire logic SMB_PRESENT_I,
    output logic [2:0] SMB_ADDR_O,
    // Debug straps and per-port status
    input wire logic DEBUG_ENABLE_N_I,
    input wire logic PORT_STATUS_OUT_ENABLE_I,
    input wire logic [2:0] PORT_STATE_I,
    output logic DEBUG_ACTIVE_O,
    output logic [4:0] DEBUG_SEL_O,
    output logic [2:0] PER_PORT_STATE_OUT_O,
    output logic [2:0] PER_PORT_STATE_OUT_OE_O,
    // Power saving strap
    input wire logic POWER_SAVE_STRAP_I,
    output logic POWER_SAVE_EN_O,
    // Scan enable pin
    input wire logic MFG_TEST_I,
    output logic SCAN_EN_O,
    output logic SCAN_EN_OE_O,
    // EEPROM pins and loader side
    input wire logic EE_XFER_ACTIVE_I,
    input wire logic EE_DATA_OUT_I,
    input wire logic EE_DATA_OE_I,
    output logic EE_DATA_IN_O,
    output logic EEPROM_SERIAL_CLOCK_O,
    input wire logic EEPROM_SERIAL_IO_I,
    output logic EEPROM_SERIAL_IO_O,
    output logic EEPROM_SERIAL_IO_OE_O,
    // Test access port pins
    input wire logic TCK_I,
    input wire logic TMS_I,
    input wire logic TDI_I,
    input wire logic TRST_N_I,
    output logic TDO_O,
    output logic TDO_OE_O
);
    // ==========================================================
    // Pin synchronisers; no reset so the strap is sampled during reset
    localparam int SW = 17;
    logic [SW-1:0] sync1_reg;
    logic [SW-1:0] sync2_reg;
    wire logic [SW-1:0] pins_raw = {GPIO_I, DEBUG_ENABLE_N_I, PORT_STATUS_OUT_ENABLE_I,
                                    POWER_SAVE_STRAP_I, MFG_TEST_I, EEPROM_SERIAL_IO_I,
                                    TCK_I, TMS_I, TDI_I, TRST_N_I};
    always_ff @(posedge SYS_CLK_I) begin
        sync1_reg <= pins_raw;
        sync2_reg <= sync1_reg;
    end

    wire logic [7:0] gpio_s = sync2_reg[16:9];
    wire logic dbg_en_n_s = sync2_reg[8];
    wire logic ps_oe_s = sync2_reg[7];
    wire logic strap_s = sync2_reg[6];
    wire logic mfg_s = sync2_reg[5];
    wire logic ee_io_s = sync2_reg[4];
    wire logic tck_s = sync2_reg[3];

    // ==========================================================
    // GPIO direction and output registers
    logic [7:0] gpio_oe_reg;
    logic [7:0] gpio_out_reg;
    logic [7:0] gpio_in_reg;
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            gpio_oe_reg <= GPIO_OE_RST;
            gpio_out_reg <= GPIO_OUT_RST;
            gpio_in_reg <= 8'h00;
        end else begin
            if (GPIO_OE_WR_I) begin
                gpio_oe_reg <= GPIO_OE_WDATA_I;
            end
            if (GPIO_OUT_WR_I) begin
                gpio_out_reg <= GPIO_OUT_WDATA_I;
            end
            gpio_in_reg <= gpio_s;
        end
    end
    assign GPIO_OE_O = gpio_oe_reg;
    assign GPIO_O = gpio_out_reg;
    assign GPIO_IN_O = gpio_in_reg;

    // ==========================================================
    // Address straps, debug mode and port status
    wire logic dbg_mode = !dbg_en_n_s;
    wire logic [2:0] smb_addr_next = SMB_PRESENT_I ? gpio_s[SMB_ADDR_HI:SMB_ADDR_LO] : 3'h0;
    wire logic [4:0] dbg_sel_next = dbg_mode ? gpio_s[DBG_SEL_HI:DBG_SEL_LO] : 5'h00;
    wire logic port_oe_next = dbg_mode && ps_oe_s;

    logic [2:0] smb_addr_reg;
    logic dbg_mode_reg;
    logic [4:0] dbg_sel_reg;
    logic [2:0] port_state_reg;
    logic [2:0] port_oe_reg;
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            smb_addr_reg <= 3'h0;
            dbg_mode_reg <= 1'b0;
            dbg_sel_reg <= 5'h00;
            port_state_reg <= 3'h0;
            port_oe_reg <= 3'h0;
        end else begin
            smb_addr_reg <= smb_addr_next;
            dbg_mode_reg <= dbg_mode;
            dbg_sel_reg <= dbg_sel_next;
            port_state_reg <= PORT_STATE_I;
            port_oe_reg <= {PORT_CNT{port_oe_next}};
        end
    end
    assign SMB_ADDR_O = smb_addr_reg;
    assign DEBUG_ACTIVE_O = dbg_mode_reg;
    assign DEBUG_SEL_O = dbg_sel_reg;
    assign PER_PORT_STATE_OUT_O = port_state_reg;
    assign PER_PORT_STATE_OUT_OE_O = port_oe_reg;

    // ==========================================================
    // Power-save strap, captured once on the first edge after release
    logic strap_done_reg;
    logic power_save_reg;
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            strap_done_reg <= 1'b0;
            power_save_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            power_save_reg <= strap_s;
        end
    end
    assign POWER_SAVE_EN_O = power_save_reg;

    // ==========================================================
    // Scan enable: driven low unless manufacturing test releases it
    logic scan_oe_reg;
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            scan_oe_reg <= 1'b1;
        end else begin
            scan_oe_reg <= !mfg_s;
        end
    end
    assign SCAN_EN_O = SCAN_EN_LEVEL;
    assign SCAN_EN_OE_O = scan_oe_reg;

    // ==========================================================
    // EEPROM clock divider and data pin
    // Clock parks low between transfers so the part sees no stray edges
    logic [7:0] ee_cnt_reg;
    logic ee_clk_reg;
    logic ee_io_reg;
    logic ee_oe_reg;
    logic ee_in_reg;
    wire logic ee_half_done = (ee_cnt_reg == EE_HALF_CYC - 8'h01);
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            ee_cnt_reg <= 8'h00;
            ee_clk_reg <= 1'b0;
            ee_io_reg <= EE_IDLE_LEVEL;
            ee_oe_reg <= 1'b1;
            ee_in_reg <= EE_IDLE_LEVEL;
        end else begin
            if (!EE_XFER_ACTIVE_I) begin
                ee_cnt_reg <= 8'h00;
                ee_clk_reg <= 1'b0;
            end else if (ee_half_done) begin
                ee_cnt_reg <= 8'h00;
                ee_clk_reg <= !ee_clk_reg;
            end else begin
                ee_cnt_reg <= ee_cnt_reg + 8'h01;
            end
            ee_io_reg <= EE_XFER_ACTIVE_I ? EE_DATA_OUT_I : EE_IDLE_LEVEL;
            ee_oe_reg <= EE_XFER_ACTIVE_I ? EE_DATA_OE_I : 1'b1;
            ee_in_reg <= ee_io_s;
        end
    end
    assign EEPROM_SERIAL_CLOCK_O = ee_clk_reg;
    assign EEPROM_SERIAL_IO_O = ee_io_reg;
    assign EEPROM_SERIAL_IO_OE_O = ee_oe_reg;
    assign EE_DATA_IN_O = ee_in_reg;

    // ==========================================================
    // Test port: TCK is oversampled, so it must stay well below 10 MHz
    logic tck_d_reg;
    logic tdo_reg;
    logic tdo_oe_reg;
    gsd_tap_if tap_bus ();
    assign tap_bus.tck_rise = tck_s && !tck_d_reg;
    assign tap_bus.tck_fall = !tck_s && tck_d_reg;
    assign tap_bus.tms = sync2_reg[2];
    assign tap_bus.tdi = sync2_reg[1];
    assign tap_bus.trst_n = sync2_reg[0];
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            tck_d_reg <= 1'b0;
            tdo_reg <= 1'b0;
            tdo_oe_reg <= 1'b0;
        end else begin
            tck_d_reg <= tck_s;
            tdo_reg <= tap_bus.tdo;
            tdo_oe_reg <= tap_bus.tdo_en;
        end
    end
    assign TDO_O = tdo_reg;
    assign TDO_OE_O = tdo_oe_reg;

    gsd_tap gsd_tap_inst (
        .clk_i(SYS_CLK_I),
        .rstn_i(RSTN_I),
        .tap(tap_bus.tap)
    );

    // ==========================================================
    // Checks
    a_gpio_oe_write:
    assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
        GPIO_OE_WR_I |=> GPIO_OE_O == $past(GPIO_OE_WDATA_I))
    else $error("GPIO enable not written");

    a_smb_addr_pins:
    assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
        SMB_PRESENT_I |=> SMB_ADDR_O == $past(gpio_s[7:5]))
    else $error("Address straps wrong");

    a_debug_sel_pins:
    assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
        !dbg_en_n_s |=> DEBUG_ACTIVE_O && DEBUG_SEL_O == $past(gpio_s[4:0]))
    else $error("Debug selection wrong");

    a_strap_held:
    assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
        strap_done_reg |=> $stable(POWER_SAVE_EN_O))
    else $error("Power-save strap changed after capture");

    a_scan_drive_low:
    assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
        !mfg_s |=> SCAN_EN_OE_O && !SCAN_EN_O)
    else $error("Scan enable not driven low");

    a_ee_idle_high:
    assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
        !EE_XFER_ACTIVE_I |=> EEPROM_SERIAL_IO_O && EEPROM_SERIAL_IO_OE_O)
    else $error("EEPROM data not held high when idle");

    a_ee_clock_period:
    assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
        (EE_XFER_ACTIVE_I && ee_half_done) |=> $changed(EEPROM_SERIAL_CLOCK_O))
    else $error("EEPROM clock did not toggle");

    a_port_oe_gate:
    assert property (@(posedge SYS_CLK_I) disable iff (!RSTN_I)
        dbg_en_n_s |=> PER_PORT_STATE_OUT_OE_O == 3'h0)
    else $error("Port status driven outside debug mode");
endmodule

// file: pkg/gsd_pkg.sv
// Shared constants and types for the GPIO, strap and debug pin block
package gsd_pkg;
    // ==========================================================
    // Pin field positions
    localparam int GPIO_W = 8;
    localparam int SMB_ADDR_HI = 7;
    localparam int SMB_ADDR_LO = 5;
    localparam int DBG_SEL_HI = 4;
    localparam int DBG_SEL_LO = 0;
    localparam int PORT_CNT = 3;
    // ==========================================================
    // Values after reset
    localparam logic [7:0] GPIO_OE_RST = 8'h00;
    localparam logic [7:0] GPIO_OUT_RST = 8'h00;
    localparam logic EE_IDLE_LEVEL = 1'h1;
    localparam logic SCAN_EN_LEVEL = 1'h0;
    // ==========================================================
    // EEPROM clock: half period in SYS_CLK_I cycles (40 MHz / 40 = 1 MHz)
    localparam logic [7:0] EE_HALF_CYC = 8'h14;
    // ==========================================================
    // Test access port
    localparam int IR_W = 2;
    localparam int DR_W = 32;
    localparam logic [1:0] IR_CAPTURE = 2'h1;
    localparam logic [1:0] IR_IDCODE = 2'h1;
    localparam logic [1:0] IR_BYPASS = 2'h3;
    // Arbitrary identification value, names no maker or part
    localparam logic [31:0] TAP_IDCODE = 32'h0000_0001;

    typedef enum logic [3:0] {
        TAP_TLR = 4'h0,
        TAP_RTI = 4'h1,
        TAP_SEL_DR = 4'h3,
        TAP_CAP_DR = 4'h2,
        TAP_SH_DR = 4'h6,
        TAP_EX1_DR = 4'h7,
        TAP_PA_DR = 4'h5,
        TAP_EX2_DR = 4'h4,
        TAP_UPD_DR = 4'hc,
        TAP_SEL_IR = 4'hd,
        TAP_CAP_IR = 4'hf,
        TAP_SH_IR = 4'he,
        TAP_EX1_IR = 4'ha,
        TAP_PA_IR = 4'hb,
        TAP_EX2_IR = 4'h9,
        TAP_UPD_IR = 4'h8
    } gsd_tap_state_e;
endpackage

// file: pkg/gsd_tap_if.sv
// Synchronised test port signals between the pin logic and the TAP
`timescale 1ns/1ps
interface gsd_tap_if;
    logic tck_rise;
    logic tck_fall;
    logic tms;
    logic tdi;
    logic trst_n;
    logic tdo;
    logic tdo_en;
    modport tap (input tck_rise, input tck_fall, input tms, input tdi, input trst_n,
                 output tdo, output tdo_en);
    modport pins (output tck_rise, output tck_fall, output tms, output tdi, output trst_n,
                  input tdo, input tdo_en);
endinterface

// file: core/gsd_tap.sv
// Test access port controller with IDCODE and BYPASS, stepped by TCK edges
`timescale 1ns/1ps
module gsd_tap
    import gsd_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Test port
    gsd_tap_if.tap tap
);
    // ==========================================================
    // State transition
    function automatic gsd_tap_state_e tap_next(input gsd_tap_state_e s, input logic m);
        gsd_tap_state_e n;
        n = TAP_TLR;
        case (s)
            TAP_TLR: n = m ? TAP_TLR : TAP_RTI;
            TAP_RTI: n = m ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: n = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: n = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: n = m ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: n = m ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR: n = m ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: n = m ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: n = m ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: n = m ? TAP_TLR : TAP_CAP_IR;
            TAP_CAP_IR: n = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: n = m ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: n = m ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR: n = m ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: n = m ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: n = m ? TAP_SEL_DR : TAP_RTI;
            default: n = TAP_TLR;
        endcase
        return n;
    endfunction

    gsd_tap_state_e state_reg;
    logic [IR_W-1:0] ir_reg;
    logic [IR_W-1:0] ir_sh_reg;
    logic [DR_W-1:0] dr_reg;
    logic tdo_reg;
    logic tdo_en_reg;

    wire gsd_tap_state_e state_next = tap_next(state_reg, tap.tms);
    wire logic is_bypass = (ir_reg == IR_BYPASS);
    wire logic in_shift = (state_reg == TAP_SH_DR) || (state_reg == TAP_SH_IR);

    // ==========================================================
    // Controller and shift registers, advanced on TCK rise
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= TAP_TLR;
            ir_reg <= IR_IDCODE;
            ir_sh_reg <= IR_CAPTURE;
            dr_reg <= '0;
        end else if (!tap.trst_n) begin
            state_reg <= TAP_TLR;
            ir_reg <= IR_IDCODE;
        end else if (tap.tck_rise) begin
            state_reg <= state_next;
            case (state_reg)
                TAP_TLR: ir_reg <= IR_IDCODE;
                TAP_CAP_IR: ir_sh_reg <= IR_CAPTURE;
                TAP_SH_IR: ir_sh_reg <= {tap.tdi, ir_sh_reg[IR_W-1:1]};
                TAP_UPD_IR: ir_reg <= ir_sh_reg;
                TAP_CAP_DR: dr_reg <= is_bypass ? '0 : TAP_IDCODE;
                TAP_SH_DR: begin
                    if (is_bypass) begin
                        dr_reg <= {{(DR_W-1){1'b0}}, tap.tdi};
                    end else begin
                        dr_reg <= {tap.tdi, dr_reg[DR_W-1:1]};
                    end
                end
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Output changes on TCK fall so the tester samples a settled bit
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tdo_reg <= 1'b0;
            tdo_en_reg <= 1'b0;
        end else if (tap.tck_fall) begin
            tdo_reg <= (state_reg == TAP_SH_IR) ? ir_sh_reg[0] : dr_reg[0];
            tdo_en_reg <= in_shift;
        end
    end

    assign tap.tdo = tdo_reg;
    assign tap.tdo_en = tdo_en_reg;

    // ==========================================================
    // Checks
    a_trst_forces_reset:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        !tap.trst_n |=> state_reg == TAP_TLR)
    else $error("TAP not reset by test reset");

    a_tms_exit_ir:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        (tap.trst_n && tap.tck_rise && tap.tms && state_reg == TAP_SEL_IR)
        |=> state_reg == TAP_TLR)
    else $error("TMS high in select-IR did not reach reset state");

    a_tdo_shift_drive:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        (tap.tck_fall && in_shift) |=> (tap.tdo_en && tap.tdo == $past(dr_reg[0])) ||
        $past(state_reg) == TAP_SH_IR)
    else $error("TDO not driven from shift register");

    a_tdo_idle_off:
    assert property (@(posedge clk_i) disable iff (!rstn_i)
        (tap.tck_fall && state_reg == TAP_RTI) |=> !tap.tdo_en)
    else $error("TDO driven outside shift");
endmodule

// file: test/gsd_partner.sv
// Board-side model: strap levels, GPIO pin wiring and EEPROM data line
`timescale 1ns/1ps
module gsd_partner (
    // Device pin drive
    input wire logic [7:0] gpio_o_i,
    input wire logic [7:0] gpio_oe_i,
    input wire logic ee_io_i,
    input wire logic ee_io_oe_i,
    // Board strap levels and EEPROM drive
    input wire logic [7:0] board_gpio_i,
    input wire logic ee_drive_i,
    input wire logic ee_val_i,
    // Resolved pin levels
    output logic [7:0] gpio_pin_o,
    output logic ee_pin_o
);
    // ==========================================================
    // Pin resolution
    // A driven pin shows the device value, else the strap resistor level
    assign gpio_pin_o = (gpio_oe_i & gpio_o_i) | (~gpio_oe_i & board_gpio_i);
    // Pull-up on the data line, so a released line never keeps a stale value
    assign ee_pin_o = ee_io_oe_i ? ee_io_i : (ee_drive_i ? ee_val_i : 1'h1);
endmodule

// file: test/gsd_top_tb.sv
// Self-checking bench for the GPIO, strap, debug and test port pin block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin errors++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module gsd_top_tb;
    import gsd_pkg::*;
    logic clk, rstn, oe_wr, out_wr, smb_p, dbg_n, ps_oe, strap, mfg, ee_act, ee_do, ee_doe;
    logic tck, tms, tdi, trst_n, ee_drive, ee_val;
    logic [7:0] oe_wd, out_wd, board, gpio_o, gpio_oe, gpio_in, gpio_pin, k;
    logic [2:0] pstate, smb_addr, pso, pso_oe;
    logic [4:0] dsel;
    logic dact, ps_en, scan, scan_oe, ee_din, ee_clk, ee_io, ee_io_oe, ee_pin, tdo, tdo_oe;
    logic [31:0] dout;
    int errors, tests_run, cycles;
    // ==========================================================
    // Design and board model
    gsd_top gsd_top_inst (.SYS_CLK_I(clk), .RSTN_I(rstn), .GPIO_I(gpio_pin), .GPIO_O(gpio_o),
        .GPIO_OE_O(gpio_oe), .GPIO_OE_WR_I(oe_wr), .GPIO_OE_WDATA_I(oe_wd),
        .GPIO_OUT_WR_I(out_wr), .GPIO_OUT_WDATA_I(out_wd), .GPIO_IN_O(gpio_in),
        .SMB_PRESENT_I(smb_p), .SMB_ADDR_O(smb_addr), .DEBUG_ENABLE_N_I(dbg_n),
        .PORT_STATUS_OUT_ENABLE_I(ps_oe), .PORT_STATE_I(pstate), .DEBUG_ACTIVE_O(dact),
        .DEBUG_SEL_O(dsel), .PER_PORT_STATE_OUT_O(pso), .PER_PORT_STATE_OUT_OE_O(pso_oe),
        .POWER_SAVE_STRAP_I(strap), .POWER_SAVE_EN_O(ps_en), .MFG_TEST_I(mfg),
        .SCAN_EN_O(scan), .SCAN_EN_OE_O(scan_oe), .EE_XFER_ACTIVE_I(ee_act),
        .EE_DATA_OUT_I(ee_do), .EE_DATA_OE_I(ee_doe), .EE_DATA_IN_O(ee_din),
        .EEPROM_SERIAL_CLOCK_O(ee_clk), .EEPROM_SERIAL_IO_I(ee_pin),
        .EEPROM_SERIAL_IO_O(ee_io), .EEPROM_SERIAL_IO_OE_O(ee_io_oe), .TCK_I(tck),
        .TMS_I(tms), .TDI_I(tdi), .TRST_N_I(trst_n), .TDO_O(tdo), .TDO_OE_O(tdo_oe));
    gsd_partner gsd_partner_inst (.gpio_o_i(gpio_o), .gpio_oe_i(gpio_oe), .ee_io_i(ee_io),
        .ee_io_oe_i(ee_io_oe), .board_gpio_i(board), .ee_drive_i(ee_drive),
        .ee_val_i(ee_val), .gpio_pin_o(gpio_pin), .ee_pin_o(ee_pin));
    // ==========================================================
    // Clock, timeout and closing report
    always #12.5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    // ==========================================================
    // Access tasks
    task automatic wr_gpio(input logic sel, input logic [7:0] d);
        @(negedge clk);
        oe_wr = ~sel;
        out_wr = sel;
        if (sel) out_wd = d; else oe_wd = d;
        @(negedge clk);
        oe_wr = 1'h0;
        out_wr = 1'h0;
    endtask
    // One test clock period; TCK held well past the synchroniser depth
    task automatic tck_step(input logic m, input logic d, output logic q);
        @(negedge clk);
        tms = m;
        tdi = d;
        cyc(5);
        q = tdo;
        tck = 1'h1;
        cyc(6);
        tck = 1'h0;
    endtask
    task automatic walk(input logic [7:0] bits, input int n);
        logic q;
        for (int i = 0; i < n; i++) tck_step(bits[i], 1'h0, q);
    endtask
    // Shift n bits LSB first, leaving on the last bit into Exit1
    task automatic shift(input int n, input logic [31:0] din, output logic [31:0] q);
        q = '0;
        for (int i = 0; i < n; i++) begin
            tck_step(i == n - 1, din[i], q[i]);
            `CHK("tdo enable", 1'h1, tdo_oe);
        end
    endtask
    task automatic read_id();
        walk(8'h02, 4);
        shift(32, 32'h0, dout);
        walk(8'h01, 2);
        `CHK("idcode", TAP_IDCODE, dout);
    endtask
    // ==========================================================
    // Tests
    initial begin
        clk = 0; rstn = 0; oe_wr = 0; out_wr = 0; smb_p = 0; dbg_n = 1; ps_oe = 0;
        strap = 1; mfg = 0; ee_act = 0; ee_do = 0; ee_doe = 0; tck = 0; tms = 1; tdi = 0;
        trst_n = 1; ee_drive = 0; ee_val = 0; oe_wd = 0; out_wd = 0; board = 8'ha3;
        pstate = 0; errors = 0; tests_run = 0; cycles = 0;
        cyc(6);
        `CHK("scan oe rst", 1'h1, scan_oe);
        `CHK("ee io rst", 2'h3, {ee_io, ee_io_oe});
        `CHK("gpio oe rst", GPIO_OE_RST, gpio_oe);
        cyc(2);
        rstn = 1;
        cyc(3);
        strap = 0;
        `CHK("power save", 1'h1, ps_en);
        cyc(6);
        `CHK("power save held", 1'h1, ps_en);
        // Second reset with the strap low: power saving must come up off
        rstn = 0;
        cyc(4);
        `CHK("power save rst", 1'h0, ps_en);
        rstn = 1;
        cyc(3);
        `CHK("power save off", 1'h0, ps_en);
        strap = 1;
        cyc(6);
        `CHK("power save off held", 1'h0, ps_en);
        $display("test reset_strap done");
        wr_gpio(1'h0, 8'ha5);
        wr_gpio(1'h0, 8'h0f);
        `CHK("gpio oe", 8'h0f, gpio_oe);
        wr_gpio(1'h1, 8'h05);
        `CHK("gpio out", 8'h05, gpio_o);
        cyc(4);
        `CHK("gpio in", 8'ha5, gpio_in);
        wr_gpio(1'h0, 8'h00);
        smb_p = 1;
        cyc(4);
        `CHK("smb addr", 3'h5, smb_addr);
        smb_p = 0;
        cyc(4);
        `CHK("smb addr off", 3'h0, smb_addr);
        $display("test gpio_smb done");
        ps_oe = 1; pstate = 3'h5;
        cyc(4);
        `CHK("no debug oe", 3'h0, pso_oe);
        `CHK("no debug sel", 5'h00, dsel);
        dbg_n = 0;
        cyc(4);
        `CHK("debug active", 1'h1, dact);
        `CHK("debug sel", 5'h03, dsel);
        `CHK("port oe", 3'h7, pso_oe);
        `CHK("port state", 3'h5, pso);
        ps_oe = 0; pstate = 3'h2;
        cyc(4);
        `CHK("port oe off", 3'h0, pso_oe);
        `CHK("port state 2", 3'h2, pso);
        dbg_n = 1;
        cyc(4);
        `CHK("normal mode", 1'h0, dact);
        $display("test debug done");
        mfg = 1;
        cyc(4);
        `CHK("scan input", 1'h0, scan_oe);
        mfg = 0;
        cyc(4);
        `CHK("scan drive", 2'h2, {scan_oe, scan});
        $display("test scan done");
        ee_act = 1; ee_doe = 0; ee_drive = 1;
        cyc(4);
        `CHK("ee release", 1'h0, ee_io_oe);
        `CHK("ee data in", 1'h0, ee_din);
        ee_drive = 0; ee_doe = 1;
        k = 0;
        while (ee_clk !== 1'h1 && k < 40) begin cyc(1); k++; end
        `CHK("ee clk rise", 1'h1, ee_clk);
        k = 0;
        while (ee_clk === 1'h1 && k < 60) begin cyc(1); k++; end
        `CHK("ee clk high", EE_HALF_CYC, k);
        `CHK("ee drive", 2'h1, {ee_io, ee_io_oe});
        k = 0;
        while (ee_clk === 1'h0 && k < 60) begin cyc(1); k++; end
        `CHK("ee clk low", EE_HALF_CYC, k);
        ee_act = 0;
        cyc(3);
        `CHK("ee idle", 3'h3, {ee_clk, ee_io, ee_io_oe});
        $display("test eeprom done");
        read_id();
        walk(8'h03, 4);
        shift(2, 32'h3, dout);
        `CHK("ir capture", IR_CAPTURE, dout[1:0]);
        // Update-IR, then straight on to Shift-DR with bypass loaded
        walk(8'h03, 4);
        shift(2, 32'h1, dout);
        walk(8'h01, 2);
        `CHK("bypass", 32'h2, dout);
        // Test reset from Run-Idle with bypass loaded must restore the ID path
        trst_n = 0;
        cyc(4);
        trst_n = 1;
        read_id();
        walk(8'h1f, 5);
        read_id();
        $display("test tap done");
        complete_run();
    end
endmodule
